//--- tswsl_slave.sv
`timescale 1ns/1ps
`default_nettype none
// Contract
// [R1] bytes shift most significant bit first, both directions
// [R2] one data bit moves per SCL period
// [R3] idle bus: both lines high, SDA released
// [R4] master opens with START and closes with STOP
// [R5] SDA changes only with SCL low; edges while SCL high are START/STOP
// [R6] receiver answers each byte with ACK/NACK in a ninth clock
// [R7] slave address decoded from three tri-state straps per table
// [R8] write address byte with R/W 0 is acknowledged on match
// [R9] pointer byte after write address is acknowledged, data follows
// [R10] master sends one config byte or two limit bytes
// [R11] each write data byte acknowledged; master ends with STOP
// [R12] 0x54 after write address: no ACK, full power-on reset
// [R13] read address acknowledged, data driven from the very next clock
// [R14] configuration read returns one byte, master NACKs then STOP
// [R15] two-byte reads: master ACKs first, NACKs second
// [R16] NACK after first byte ends transmission after the high byte
// [R17] master writes pointer first to read another register
// [R18] repeated START after pointer byte starts a normal read
// [R19] pointer low two bits select temp, config, hysteresis, over-temp
// [R20] pointer kept across reads until a new pointer byte
// [R21] master sends a fresh pointer with every write
// [R22] pointer selects temperature after power-up and soft reset
// [R23] address mismatch: SDA stays released for rest of transaction
// [R24] STOP or START mid-transaction aborts and awaits an address
module tswsl_slave (
  // clock and reset
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset_n,
  // two-wire bus pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe,
  // address straps, level codes from pad sensing
  input  wire logic [1:0]  i_addr_strap_0,
  input  wire logic [1:0]  i_addr_strap_1,
  input  wire logic [1:0]  i_addr_strap_2,
  // register file side
  output logic [1:0]       o_reg_ptr,
  input  wire logic [15:0] i_rd_data,
  output logic             o_wr_stb,
  output logic             o_wr_byte_idx,
  output logic [7:0]       o_wr_data,
  output logic             o_soft_reset
);
  import tswsl_pkg::*;

  logic               scl_m, scl_s, scl_q, sda_m, sda_s, sda_q;
  logic [5:0]         strap_m, strap_s;
  tswsl_state_t       state_r;
  logic [2:0]         cnt_r;
  logic               done_r, rw_r, mack_r, second_r, idx_r;
  logic [7:0]         rx_r, tx_r;
  logic [1:0]         ptr_r;
  logic               oe_r, wr_stb_r, wr_idx_r, por_r;
  logic [7:0]         wr_data_r;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
    begin
      {scl_m, scl_s, scl_q, sda_m, sda_s, sda_q} <= 6'h3F;
      strap_m <= 6'h00;
      strap_s <= 6'h00;
    end
    else
    begin
      {scl_m, scl_s, scl_q} <= {i_scl, scl_m, scl_s};
      {sda_m, sda_s, sda_q} <= {i_sda, sda_m, sda_s};
      strap_m <= {i_addr_strap_2, i_addr_strap_1, i_addr_strap_0};
      strap_s <= strap_m;
    end
  end

  wire       scl_rise  = scl_s & ~scl_q;
  wire       scl_fall  = ~scl_s & scl_q;
  wire       start_det = scl_s & scl_q & sda_q & ~sda_s; // [R5]
  wire       stop_det  = scl_s & scl_q & ~sda_q & sda_s; // [R5]
  wire [6:0] my_addr   = strap_addr(strap_s[5:4], strap_s[3:2], strap_s[1:0]); // [R7]
  wire       addr_hit  = (rx_r[7:1] == my_addr);
  wire       rx_state  = (state_r == ST_ADDR) || (state_r == ST_PTR) || (state_r == ST_WDATA);
  wire       byte_end  = scl_fall & done_r;
  wire       two_byte  = (ptr_r != PTR_CONFIG);
  wire       por_cmd   = (rx_r == SOFT_POR_CMD);
  wire [7:0] rd_hi     = i_rd_data[15:8];
  wire [7:0] rd_lo     = i_rd_data[7:0];

  always_ff @(posedge i_sys_clk)
  begin
    wr_stb_r <= 1'b0;
    por_r    <= 1'b0;
    if (!i_reset_n || por_r)
    begin
      state_r   <= ST_IDLE;
      cnt_r     <= 3'h0;
      done_r    <= 1'b0;
      rw_r      <= 1'b0;
      mack_r    <= 1'b0;
      second_r  <= 1'b0;
      idx_r     <= 1'b0;
      rx_r      <= 8'h00;
      tx_r      <= 8'h00;
      ptr_r     <= PTR_RESET; // [R22]
      oe_r      <= 1'b0;
      wr_idx_r  <= 1'b0;
      wr_data_r <= 8'h00;
    end
    else if (start_det)
    begin
      state_r <= ST_ADDR; // [R24] [R18]
      cnt_r   <= 3'h0;
      done_r  <= 1'b0;
      oe_r    <= 1'b0;
    end
    else if (stop_det)
    begin
      state_r <= ST_IDLE; // [R24] [R3]
      oe_r    <= 1'b0;
    end
    else if (scl_rise)
    begin
      if (rx_state)
      begin
        rx_r   <= {rx_r[6:0], sda_s}; // [R1] [R2]
        cnt_r  <= cnt_r + 3'h1;
        done_r <= (cnt_r == BIT_LAST);
      end
      if (state_r == ST_RACK)
        mack_r <= ~sda_s;
    end
    else if (scl_fall)
    begin
      done_r <= 1'b0;
      unique case (state_r)
        ST_ADDR:
          if (done_r)
          begin
            rw_r    <= rx_r[0];
            oe_r    <= addr_hit; // [R8] [R13]
            state_r <= addr_hit ? ST_ADDR_ACK : ST_IGNORE; // [R23]
          end
        ST_ADDR_ACK:
          if (rw_r)
          begin
            tx_r     <= rd_hi; // [R13]
            oe_r     <= ~rd_hi[7]; // [R1]
            cnt_r    <= 3'h0;
            second_r <= 1'b0;
            state_r  <= ST_RDATA;
          end
          else
          begin
            oe_r    <= 1'b0;
            state_r <= ST_PTR;
          end
        ST_PTR:
          if (done_r && por_cmd)
          begin
            por_r   <= 1'b1; // [R12]
            state_r <= ST_IGNORE;
          end
          else if (done_r)
          begin
            ptr_r   <= rx_r[PTR_SEL_BITS-1:0]; // [R19] [R20]
            oe_r    <= 1'b1; // [R9]
            state_r <= ST_PTR_ACK;
          end
        ST_PTR_ACK:
        begin
          oe_r    <= 1'b0;
          idx_r   <= 1'b0;
          state_r <= ST_WDATA;
        end
        ST_WDATA:
          if (done_r)
          begin
            oe_r      <= 1'b1; // [R11] [R6]
            wr_stb_r  <= 1'b1;
            wr_idx_r  <= idx_r;
            wr_data_r <= rx_r;
            state_r   <= ST_WDATA_ACK;
          end
        ST_WDATA_ACK:
        begin
          oe_r    <= 1'b0;
          idx_r   <= 1'b1;
          state_r <= ST_WDATA;
        end
        ST_RDATA:
          if (cnt_r == BIT_LAST)
          begin
            oe_r    <= 1'b0; // [R6]
            state_r <= ST_RACK;
          end
          else
          begin
            oe_r  <= ~tx_r[6]; // [R1] [R2]
            tx_r  <= {tx_r[6:0], 1'b0};
            cnt_r <= cnt_r + 3'h1;
          end
        ST_RACK:
          if (mack_r && !second_r && two_byte)
          begin
            tx_r     <= rd_lo; // [R15]
            oe_r     <= ~rd_lo[7];
            cnt_r    <= 3'h0;
            second_r <= 1'b1;
            state_r  <= ST_RDATA;
          end
          else
            state_r <= ST_IGNORE; // [R14] [R16]
        ST_IDLE, ST_IGNORE:
          oe_r <= 1'b0;
      endcase
    end
  end

  assign o_sda_out     = 1'b0;
  assign o_sda_oe      = oe_r;
  assign o_reg_ptr     = ptr_r;
  assign o_wr_stb      = wr_stb_r;
  assign o_wr_byte_idx = wr_idx_r;
  assign o_wr_data     = wr_data_r;
  assign o_soft_reset  = por_r;

  sequence s_addr_end;
    scl_fall && done_r && state_r == ST_ADDR;
  endsequence
  sequence s_ack_slot;
    oe_r && !scl_fall;
  endsequence

  property p_idle_released;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      state_r == ST_IDLE |-> !oe_r;
  endproperty
  a_idle_released: assert property (p_idle_released) else $error("sda driven while idle"); // [R3]

  property p_addr_ack;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      s_addr_end and addr_hit |=> s_ack_slot [*1] ##0 state_r == ST_ADDR_ACK;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("matching address not acked"); // [R8]

  property p_mismatch;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      s_addr_end and !addr_hit |=> !oe_r && state_r == ST_IGNORE;
  endproperty
  a_mismatch: assert property (p_mismatch) else $error("foreign address answered"); // [R23]

  property p_soft_por;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      scl_fall && done_r && state_r == ST_PTR && por_cmd
        |=> por_r && !oe_r ##1 ptr_r == PTR_RESET && state_r == ST_IDLE;
  endproperty
  a_soft_por: assert property (p_soft_por) else $error("soft reset not taken"); // [R12]

  property p_ptr_kept;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      !$stable(ptr_r) |-> $past(state_r) == ST_PTR || $past(por_r);
  endproperty
  a_ptr_kept: assert property (p_ptr_kept) else $error("pointer changed outside write"); // [R20]

  property p_abort;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      start_det && !por_r |=> state_r == ST_ADDR && !oe_r && cnt_r == 3'h0;
  endproperty
  a_abort: assert property (p_abort) else $error("start did not restart"); // [R24]

  property p_read_msb;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      scl_fall && state_r == ST_ADDR_ACK && rw_r && !start_det && !stop_det
        |=> state_r == ST_RDATA && oe_r == ~$past(rd_hi[7]);
  endproperty
  a_read_msb: assert property (p_read_msb) else $error("read data not on next clock"); // [R13]

  property p_wr_ack;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      scl_fall && done_r && state_r == ST_WDATA
        |=> o_wr_stb && oe_r && o_wr_data == $past(rx_r);
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write byte not acked"); // [R11]

  property p_one_byte;
    @(posedge i_sys_clk) disable iff (!i_reset_n)
      scl_fall && state_r == ST_RACK && (!mack_r || second_r || !two_byte)
        |=> state_r == ST_IGNORE ##1 !oe_r;
  endproperty
  a_one_byte: assert property (p_one_byte) else $error("transmission went on"); // [R16]
endmodule : tswsl_slave
`default_nettype wire

//--- tswsl_pkg.sv
`default_nettype none
package tswsl_pkg;
  localparam logic [3:0] ADDR_FIXED_HI  = 4'h9;
  localparam logic [7:0] SOFT_POR_CMD   = 8'h54;
  localparam logic [1:0] PTR_TEMP       = 2'h0;
  localparam logic [1:0] PTR_CONFIG     = 2'h1;
  localparam logic [1:0] PTR_HYST       = 2'h2;
  localparam logic [1:0] PTR_OVER_TEMP  = 2'h3;
  localparam logic [1:0] PTR_RESET      = PTR_TEMP;
  localparam int         PTR_SEL_BITS   = 2;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  // strap level codes as delivered by the pad sensing logic
  localparam logic [1:0] STRAP_LOW      = 2'h0;
  localparam logic [1:0] STRAP_HIGH     = 2'h1;
  localparam logic [1:0] STRAP_FLOAT    = 2'h2;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK, ST_IGNORE
  } tswsl_state_t;

  function automatic logic is_float(input logic [1:0] s);
    return s[1];
  endfunction : is_float

  // 7-bit slave address from the three tri-state straps
  function automatic logic [6:0] strap_addr(input logic [1:0] s2,
                                            input logic [1:0] s1,
                                            input logic [1:0] s0);
    logic [5:0] k;
    // code 11 folds onto float so a stray pad code still decodes
    k = {s2[1], s2[0] & ~s2[1], s1[1], s1[0] & ~s1[1], s0[1], s0[0] & ~s0[1]};
    if (!is_float(s2) && !is_float(s1) && !is_float(s0))
      return {ADDR_FIXED_HI, s2[0], s1[0], s0[0]};
    unique case (k)
      6'h02:   return 7'h2C;
      6'h08:   return 7'h28;
      6'h06:   return 7'h2D;
      6'h09:   return 7'h29;
      6'h0A:   return 7'h35;
      6'h12:   return 7'h2E;
      6'h18:   return 7'h2A;
      6'h16:   return 7'h2F;
      6'h19:   return 7'h2B;
      6'h1A:   return 7'h36;
      6'h20:   return 7'h70;
      6'h21:   return 7'h72;
      6'h24:   return 7'h73;
      6'h25:   return 7'h75;
      6'h22:   return 7'h71;
      6'h28:   return 7'h76;
      6'h26:   return 7'h74;
      6'h29:   return 7'h77;
      6'h2A:   return 7'h37;
      default: return 7'h37;
    endcase
  endfunction : strap_addr
endpackage : tswsl_pkg
`default_nettype wire

//--- tswsl_dummy_never.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- tswsl_bfm.sv
`timescale 1ns/1ps
`default_nettype none
module tswsl_bfm #(
  parameter int HALF = 6
) (
  // clock, bus line and pace
  input  wire logic       i_sys_clk,
  input  wire logic       i_sda,
  input  wire logic       i_slow,
  // driven bus lines
  output logic            o_scl,
  output logic            o_sda,
  // bytes read back
  output logic            o_rd_vld,
  output logic [7:0]      o_rd_byte
);
  initial
  begin
    o_scl     = 1'b1;
    o_sda     = 1'b1;
    o_rd_vld  = 1'b0;
    o_rd_byte = 8'h00;
  end
  task automatic hw(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : hw
  // from scl low this is a repeated start
  task automatic start_cond();
    o_sda = 1'b1;
    hw(HALF);
    o_scl = 1'b1;
    hw(HALF);
    o_sda = 1'b0;
    hw(HALF);
    o_scl = 1'b0;
    hw(HALF);
  endtask : start_cond
  task automatic stop_cond();
    o_sda = 1'b0;
    hw(HALF);
    o_scl = 1'b1;
    hw(HALF);
    o_sda = 1'b1;
    hw(HALF);
  endtask : stop_cond
  // data moves a half period after the fall, never next to an scl edge
  task automatic bit_io(input logic b, output logic r);
    o_sda = b;
    hw(HALF);
    o_scl = 1'b1;
    hw(i_slow ? 3 * HALF : HALF);
    r     = i_sda;
    o_scl = 1'b0;
    hw(HALF);
  endtask : bit_io
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : wr_byte
  // nack marks the last byte wanted
  task automatic rd_byte(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~ack_it, r);
    o_rd_byte = d;
    o_rd_vld  = 1'b1;
    hw(1);
    o_rd_vld  = 1'b0;
  endtask : rd_byte
endmodule : tswsl_bfm
`default_nettype wire

//--- tswsl_slave_tb.sv
`timescale 1ns/1ps
`default_nettype none
module tswsl_slave_tb;
  import tswsl_pkg::*;
  logic        sys_clk, reset_n, scl, sda_m, sda_out, sda_oe, slow, rd_vld, ack;
  logic        wr_stb, wr_idx, soft_rst;
  logic [1:0]  st0, st1, st2, reg_ptr;
  logic [7:0]  rd_byte, wr_data;
  logic [6:0]  my_a;
  logic [31:0] s;
  logic [8:0]  exp_q[$];
  int          n_errors, samples_checked, n_sr;
  integer      seed;
  function automatic logic [15:0] reg_val(input logic [1:0] p);
    return 16'hC35A ^ {8{p}};
  endfunction : reg_val
  // pull-up: line low only when someone pulls it
  wire logic   sda = (sda_oe ? sda_out : 1'b1) & sda_m;
  wire logic [15:0] rd_data = reg_val(reg_ptr);
  tswsl_slave u_tswsl_slave (.i_sys_clk(sys_clk), .i_reset_n(reset_n), .i_scl(scl),
    .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .i_addr_strap_0(st0),
    .i_addr_strap_1(st1), .i_addr_strap_2(st2), .o_reg_ptr(reg_ptr), .i_rd_data(rd_data),
    .o_wr_stb(wr_stb), .o_wr_byte_idx(wr_idx), .o_wr_data(wr_data), .o_soft_reset(soft_rst));
  tswsl_bfm u_tswsl_bfm (.i_sys_clk(sys_clk), .i_sda(sda), .i_slow(slow), .o_scl(scl),
    .o_sda(sda_m), .o_rd_vld(rd_vld), .o_rd_byte(rd_byte));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ptr_set(input logic [6:0] a, input logic [1:0] p);
    u_tswsl_bfm.start_cond();
    u_tswsl_bfm.wr_byte({a, 1'b0}, ack);
    chk(16'(ack), 16'h0001);
    u_tswsl_bfm.wr_byte({6'h00, p}, ack);
    chk(16'(ack), 16'h0001);
    chk(16'(reg_ptr), 16'(p));
  endtask : ptr_set
  task automatic write_tx(input logic [6:0] a, input logic [1:0] p, input int n);
    logic [7:0] d;
    ptr_set(a, p);
    for (int i = 0; i < n; i++)
    begin
      d = 8'($random(seed));
      exp_q.push_back({(i > 0), d});
      u_tswsl_bfm.wr_byte(d, ack);
      chk(16'(ack), 16'h0001);
    end
    u_tswsl_bfm.stop_cond();
  endtask : write_tx
  task automatic read_tx(input logic [6:0] a, input logic [1:0] p, input int n);
    logic [15:0] v;
    logic [7:0]  d;
    v = reg_val(p);
    u_tswsl_bfm.start_cond();
    u_tswsl_bfm.wr_byte({a, 1'b1}, ack);
    chk(16'(ack), 16'h0001);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back({1'b0, (i == 0) ? v[15:8] : v[7:0]});
      u_tswsl_bfm.rd_byte(i < n - 1, d);
    end
    u_tswsl_bfm.stop_cond();
    chk(16'(sda), 16'h0001);
  endtask : read_tx
  always @(posedge sys_clk)
  begin
    if (wr_stb === 1'b1 || rd_vld === 1'b1)
      chk(16'(wr_stb ? {wr_idx, wr_data} : {1'b0, rd_byte}),
          (exp_q.size() > 0) ? 16'(exp_q.pop_front()) : 16'hFFFF);
    if (soft_rst === 1'b1)
      n_sr++;
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end
  initial
  begin
    seed = 78;
    reset_n = 1'b0;
    slow = 1'b0;
    st0 = STRAP_LOW;
    st1 = STRAP_LOW;
    st2 = STRAP_LOW;
    my_a = {ADDR_FIXED_HI, 3'h0};
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(16'(reg_ptr), 16'(PTR_RESET));
    read_tx(my_a, PTR_RESET, 2);
    for (int k = 0; k < 4; k++)
    begin
      s = $random(seed);
      st0 = {1'b0, s[0]};
      st1 = {1'b0, s[1]};
      st2 = {1'b0, s[2]};
      slow = s[3];
      my_a = {ADDR_FIXED_HI, s[2:0]};
      write_tx(my_a, k[1:0], (k == 1) ? 1 : 2);
      read_tx(my_a, k[1:0], (k == 1) ? 1 : 2);
    end
    u_tswsl_bfm.start_cond();
    u_tswsl_bfm.wr_byte({my_a, 1'b0}, ack);
    chk(16'(ack), 16'h0001);
    u_tswsl_bfm.wr_byte(SOFT_POR_CMD, ack);
    chk(16'(ack), 16'h0000);
    u_tswsl_bfm.stop_cond();
    chk(16'(n_sr), 16'h0001);
    chk(16'(reg_ptr), 16'(PTR_RESET));
    u_tswsl_bfm.start_cond();
    u_tswsl_bfm.wr_byte({my_a ^ 7'h01, 1'b1}, ack);
    chk(16'(ack), 16'h0000);
    u_tswsl_bfm.stop_cond();
    u_tswsl_bfm.start_cond();
    u_tswsl_bfm.wr_byte({my_a, 1'b0}, ack);
    repeat (3) u_tswsl_bfm.bit_io(1'b1, ack);
    read_tx(my_a, PTR_RESET, 2);
    ptr_set(my_a, PTR_CONFIG);
    read_tx(my_a, PTR_CONFIG, 1);
    ptr_set(my_a, PTR_OVER_TEMP);
    read_tx(my_a, PTR_OVER_TEMP, 1);
    slow = 1'b1;
    st2 = STRAP_FLOAT;
    st1 = STRAP_LOW;
    st0 = STRAP_LOW;
    read_tx(7'h70, PTR_OVER_TEMP, 2);
    repeat (4) @(negedge sys_clk);
    chk(16'(exp_q.size()), 16'h0000);
    end_sim();
  end
endmodule : tswsl_slave_tb
`default_nettype wire
